// file: hdl/adc_host_ctrl.sv
// host controller that drives a 16k x 1 multiplexed-address dynamic ram
//
// Notes on behaviour
// R1 - eight refresh cycles before first use
// R2 - read cycles spaced by grade cycle time
// R3 - write cycles spaced by grade cycle time
// R4 - write strobe high across whole read
// R5 - read hold from first trailing strobe
// R6 - early write keeps data out floating
// R7 - late write after delays reads data
// R8 - other write timings leave data undefined
// R9 - write strobe held long from row fall
// R10 - write pulse at least grade width
// R11 - write strobe leads row strobe rise
// R12 - write strobe leads column strobe rise
// R13 - write data held long past row fall
// R14 - data timed from later strobe falling
// R15 - read-modify-write cycles spaced by grade time
// R16 - rmw row strobe low within limits
// R17 - rmw column strobe low within limits
// R18 - late column strobe lengthens access time
// R19 - page column cycles spaced by minimum
// R20 - page rmw column cycles spaced wider
// R21 - column precharge between page cycles
// R22 - page row strobe width within limits
// R23 - column-to-row precharge after column-only cycles
// R24 - read keeps write strobe high
// R25 - every row refreshed within retention period
// R26 - data out follows column strobe low
// R27 - hidden refresh keeps latched output
// R28 - times become clock counts, rounded safely
`timescale 1ns/100ps
module adc_host_ctrl
  import adc_pkg::*;
#(
  parameter int GRADE      = 0,
  parameter bit PAGE_EN    = 1'b1,
  parameter int INTERVAL_C = cyc_max(REFRESH_PERIOD_NS / REFRESH_ROWS)
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire adc_cmd_e          req_cmd_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic              req_wdata_i,
  output logic                   rsp_valid_o,
  output logic                   rsp_rdata_o,
  output logic                   init_done_o,
  output logic                   dram_ras_n_o,
  output logic                   dram_cas_n_o,
  output logic                   dram_we_n_o,
  output logic [ROW_W-1:0]       dram_addr_o,
  output logic                   dram_din_o,
  input  wire logic              dram_dout_i
);

  // timing in cycles; least times round up, longest round down
  localparam int ROW_C  = cyc_min(max2(T_RAH_NS[GRADE],
                                       T_RCD_MIN_NS[GRADE])); // see R28
  localparam int RC_C   = cyc_min(T_RC_NS[GRADE]);
  localparam int RWC_C  = cyc_min(T_RWC_NS[GRADE]);
  // access times get one ns more: read data must never change on the
  // very edge that samples it, even when a time is a whole clock count
  localparam int RAS_C  = cyc_min(max2(T_RAS_NS[GRADE], T_RAC_NS[GRADE] + 1));
  localparam int CAS_C  = cyc_min(max2(T_CAS_NS[GRADE], T_CAC_NS[GRADE] + 1));
  localparam int RP_C   = cyc_min(T_RP_NS[GRADE]);
  localparam int CWD_C  = cyc_min(max2(T_CWD_NS[GRADE], T_CAC_NS[GRADE] + 1));
  localparam int RWD_C  = cyc_min(max2(T_RWD_NS[GRADE], T_RAC_NS[GRADE] + 1));
  localparam int WL_C   = cyc_min(max2(max2(T_WP_NS[GRADE], T_WCH_NS[GRADE]),
                                       max2(T_RWL_NS[GRADE],
                                            T_CWL_NS[GRADE])));
  localparam int CRW_C  = cyc_min(T_CRW_NS[GRADE]);
  localparam int RRW_C  = cyc_min(T_RRW_NS[GRADE]);
  localparam int PC_C   = cyc_min(T_PC_NS[GRADE]);
  localparam int PRMW_C = cyc_min(T_PRMW_NS[GRADE]);
  localparam int CP_C   = cyc_min(T_CP_NS[GRADE]);
  localparam int SMAX_C = cyc_max(STROBE_MAX_NS);
  // worst page column cycle still to come, plus margin
  localparam int GUARD_C = CP_C + 1 + CWD_C + WL_C + CRW_C + 2;

  initial begin
    if (GRADE < 0 || GRADE >= NUM_GRADES)
      $error("speed grade out of range");
    if (SMAX_C > 1023 || GUARD_C >= SMAX_C)
      $error("strobe limits do not fit counters");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_ROW, S_COL, S_CAS, S_RMW_WR, S_PAGE_PRE, S_RAS_PRE, S_REF
  } adc_state_e;

  adc_state_e        state_q, state_d;
  logic [7:0]        cnt_q;
  logic [9:0]        ras_age_q;
  logic [7:0]        cas_age_q;
  logic              have_q;
  adc_cmd_e          cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic              wdata_q;
  logic              last_rmw_q;
  logic [ROW_W-1:0]  ref_row_q;
  logic [ROW_W-1:0]  dram_addr_row_q;
  logic              ref_due;
  logic              ref_done;
  logic              take;
  logic              page_ok;
  logic              row_hit;
  logic              ras_n_d;
  logic              cas_n_d;
  logic              ready_d;

  // true when counter value k means at least n cycles have passed
  function automatic logic reached(input int k, input int n);
    return k >= n - 1;
  endfunction

  assign take     = req_valid_i && req_ready_o;
  assign ref_done = (state_q == S_REF) && (state_d == S_RAS_PRE);
  assign row_hit  = (addr_q[ROW_W-1:0] == dram_addr_row_q);
  // page only while refresh is not owed and the row strobe has headroom
  assign page_ok  = PAGE_EN && !ref_due &&
                    (int'(ras_age_q) < SMAX_C - GUARD_C); // see R22

  adc_refresh_sched #(
    .INTERVAL_C (INTERVAL_C)
  ) u_sched (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .done_i      (ref_done),
    .due_o       (ref_due),
    .init_done_o (init_done_o)
  );

  // cycle sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (have_q) begin
          state_d = S_ROW;
        end else if (ref_due) begin
          state_d = S_REF; // see R25
        end
      end
      S_ROW: begin
        if (reached(int'(cnt_q), ROW_C)) begin
          state_d = S_COL;
        end
      end
      S_COL: begin
        state_d = S_CAS;
      end
      S_CAS: begin
        if (cmd_q == ADC_CMD_RMW) begin
          // write strobe only after both delays: a true rmw
          if (reached(int'(cas_age_q), CWD_C) &&
              reached(int'(ras_age_q), RWD_C)) begin
            state_d = S_RMW_WR; // see R7
          end
        end else if (reached(int'(cas_age_q), CAS_C) &&
                     reached(int'(ras_age_q), RAS_C)) begin
          // access is the later of row access and delay plus column access
          state_d = page_ok ? S_PAGE_PRE : S_RAS_PRE; // see R18
        end
      end
      S_RMW_WR: begin
        if (reached(int'(cnt_q), WL_C) &&
            reached(int'(cas_age_q), CRW_C) &&
            reached(int'(ras_age_q), RRW_C)) begin
          state_d = page_ok ? S_PAGE_PRE : S_RAS_PRE; // see R16 R17
        end
      end
      S_PAGE_PRE: begin
        // column precharge and column cycle spacing both met
        if (reached(int'(cnt_q), CP_C) && // see R21
            reached(int'(cas_age_q), last_rmw_q ? PRMW_C : PC_C)) begin
          state_d = (have_q && row_hit) ? S_COL : S_RAS_PRE; // see R19 R20
        end
      end
      S_RAS_PRE: begin
        if (reached(int'(cnt_q), RP_C) &&
            reached(int'(ras_age_q), last_rmw_q ? RWC_C : RC_C)) begin
          state_d = S_IDLE; // see R2 R3 R15
        end
      end
      S_REF: begin
        if (reached(int'(ras_age_q), RAS_C)) begin
          state_d = S_RAS_PRE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // strobe levels follow the next state so the pins come from flops
  always_comb begin
    ras_n_d = !(state_d inside {S_ROW, S_COL, S_CAS, S_RMW_WR,
                                S_PAGE_PRE, S_REF});
    // column strobe only inside a row cycle: no column-only cycles, and
    // no hidden refresh, so no column-to-row precharge case arises
    cas_n_d = !(state_d inside {S_CAS, S_RMW_WR}); // see R23 R27
    ready_d = !take && !have_q && init_done_o &&
              ((state_d == S_IDLE && !ref_due) ||
               (state_d == S_PAGE_PRE && state_q != S_PAGE_PRE));
  end

  // state and dwell counter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= S_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        cnt_q <= 8'h00;
      end else if (cnt_q != 8'hff) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // strobe ages, restarted on each falling edge, saturating
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ras_age_q <= 10'h3ff;
      cas_age_q <= 8'hff;
    end else begin
      if (dram_ras_n_o && !ras_n_d) begin
        ras_age_q <= 10'h000;
      end else if (ras_age_q != 10'h3ff) begin
        ras_age_q <= ras_age_q + 10'h001;
      end
      if (dram_cas_n_o && !cas_n_d) begin
        cas_age_q <= 8'h00;
      end else if (cas_age_q != 8'hff) begin
        cas_age_q <= cas_age_q + 8'h01;
      end
    end
  end

  // accepted request; kept until its column cycle starts
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      have_q      <= 1'b0;
      cmd_q       <= ADC_CMD_READ;
      addr_q      <= '0;
      wdata_q     <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= ready_d;
      if (take) begin
        have_q  <= 1'b1;
        cmd_q   <= req_cmd_i;
        addr_q  <= req_addr_i;
        wdata_q <= req_wdata_i;
      end else if (state_d == S_COL) begin
        have_q <= 1'b0;
      end
    end
  end

  // which cycle kind sets the spacing of the next one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_rmw_q <= 1'b0;
    end else if (state_d == S_REF) begin
      last_rmw_q <= 1'b0;
    end else if (state_q == S_CAS && state_d != S_CAS) begin
      last_rmw_q <= (cmd_q == ADC_CMD_RMW);
    end
  end

  // refresh row walks all rows in turn
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_row_q <= '0;
    end else if (ref_done) begin
      ref_row_q <= ref_row_q + 1'b1; // see R25
    end
  end

  // pins: strobes, multiplexed address, write data
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dram_ras_n_o    <= 1'b1;
      dram_cas_n_o    <= 1'b1;
      dram_we_n_o     <= 1'b1;
      dram_addr_o     <= '0;
      dram_addr_row_q <= '0;
      dram_din_o      <= 1'b0;
    end else begin
      dram_ras_n_o <= ras_n_d;
      dram_cas_n_o <= cas_n_d;
      // early write: strobe low a cycle before cas falls, up with cas;
      // a read never lowers it, so read setup and hold are met
      dram_we_n_o <= !((cmd_q == ADC_CMD_WRITE &&
                        state_d inside {S_COL, S_CAS}) ||
                       state_d == S_RMW_WR); // see R4 R5 R24 R6
      // write strobe spans from before cas fall to cas rise, so the
      // pulse and lead times exceed the cas width and the hold time equals it
      if (state_d == S_ROW) begin
        dram_addr_o     <= addr_q[ROW_W-1:0];
        dram_addr_row_q <= addr_q[ROW_W-1:0];
      end else if (state_d == S_REF) begin
        dram_addr_o     <= ref_row_q;
        dram_addr_row_q <= ref_row_q;
      end else if (state_d == S_COL) begin
        dram_addr_o <= addr_q[ADDR_W-1:ROW_W];
      end
      // data set with the write strobe, held until cas rises
      if (state_d == S_COL || state_d == S_RMW_WR) begin
        dram_din_o <= wdata_q; // see R9 R10 R11 R12 R13 R14
      end
    end
  end

  // read data: end of the cas pulse, or just before the rmw write
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (state_q == S_CAS && state_d != S_CAS &&
          cmd_q != ADC_CMD_WRITE) begin
        rsp_valid_o <= 1'b1;
        rsp_rdata_o <= dram_dout_i; // see R26 R7
      end
    end
  end

endmodule

// file: include/adc_pkg.sv
// shared constants, timing tables and types for the dram cycle controller
package adc_pkg;

  // controller clock
  localparam int CLK_PERIOD_NS = 25;

  // array organisation: 7 multiplexed address pins, 14 address bits
  localparam int ROW_W        = 7;
  localparam int ADDR_W       = 14;
  localparam int NUM_GRADES   = 3;
  localparam int REFRESH_ROWS = 128;
  localparam int INIT_CYCLES  = 8;

  // retention and strobe limits in ns
  localparam int REFRESH_PERIOD_NS = 2000000;
  localparam int STROBE_MAX_NS     = 10000;

  // per speed grade, fastest first, all in ns
  localparam int T_RC_NS      [NUM_GRADES] = '{320, 375, 410};
  localparam int T_RAS_NS     [NUM_GRADES] = '{150, 200, 250};
  localparam int T_CAS_NS     [NUM_GRADES] = '{100, 135, 165};
  localparam int T_RP_NS      [NUM_GRADES] = '{100, 120, 150};
  localparam int T_RAC_NS     [NUM_GRADES] = '{150, 200, 250};
  localparam int T_CAC_NS     [NUM_GRADES] = '{100, 135, 165};
  localparam int T_RCD_MIN_NS [NUM_GRADES] = '{20, 25, 35};
  localparam int T_RAH_NS     [NUM_GRADES] = '{20, 25, 35};
  localparam int T_WCH_NS     [NUM_GRADES] = '{45, 55, 75};
  localparam int T_WP_NS      [NUM_GRADES] = '{45, 55, 75};
  localparam int T_RWL_NS     [NUM_GRADES] = '{60, 80, 100};
  localparam int T_CWL_NS     [NUM_GRADES] = '{60, 80, 100};
  localparam int T_RWC_NS     [NUM_GRADES] = '{330, 375, 475};
  localparam int T_RRW_NS     [NUM_GRADES] = '{185, 245, 305};
  localparam int T_CRW_NS     [NUM_GRADES] = '{135, 180, 230};
  localparam int T_RWD_NS     [NUM_GRADES] = '{120, 160, 200};
  localparam int T_CWD_NS     [NUM_GRADES] = '{70, 95, 125};
  localparam int T_PC_NS      [NUM_GRADES] = '{170, 225, 275};
  localparam int T_PRMW_NS    [NUM_GRADES] = '{205, 270, 340};
  localparam int T_CP_NS      [NUM_GRADES] = '{60, 80, 100};

  // user commands
  typedef enum logic [1:0] {
    ADC_CMD_READ  = 2'h0,
    ADC_CMD_WRITE = 2'h1,
    ADC_CMD_RMW   = 2'h2
  } adc_cmd_e;

  // least time to cycles, rounded up, never under one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // longest time to cycles, rounded down, never under one cycle
  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

endpackage

// file: hdl/adc_refresh_sched.sv
// refresh scheduler: power-up burst plus one row per interval
`timescale 1ns/100ps
module adc_refresh_sched
  import adc_pkg::*;
#(
  parameter int INTERVAL_C = 625
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic done_i,
  output logic      due_o,
  output logic      init_done_o
);

  localparam int PEND_W = 4;

  initial begin
    if (INTERVAL_C < 2 || INTERVAL_C > 65535)
      $error("refresh interval out of range");
  end

  logic [15:0]       timer_q;
  logic              tick;
  logic [PEND_W-1:0] pending_q;
  logic [3:0]        served_q;

  assign tick = (timer_q == 16'(INTERVAL_C - 1));

  // free running interval timer
  always_ff @(posedge clk_i) begin
    if (reset_i || tick) begin
      timer_q <= 16'h0000;
    end else begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // owed refreshes; a tick in the same cycle as a done keeps the count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pending_q <= PEND_W'(INIT_CYCLES); // see R1
    end else if (tick && !done_i && pending_q != '1) begin
      pending_q <= pending_q + 1'b1; // see R25
    end else if (done_i && !tick && pending_q != '0) begin
      pending_q <= pending_q - 1'b1;
    end
  end

  // power-up burst is over once eight refreshes have run
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      served_q    <= 4'h0;
      init_done_o <= 1'b0;
    end else if (done_i && !init_done_o) begin
      served_q    <= served_q + 4'h1;
      init_done_o <= (served_q == 4'(INIT_CYCLES - 1)); // see R1
    end
  end

  // registered so that the fsm sees a clean level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      due_o <= 1'b1;
    end else begin
      due_o <= (pending_q > PEND_W'(1)) ||
               (pending_q == PEND_W'(1) && !done_i) || tick;
    end
  end

endmodule

// file: verif/adc_dram_model.sv
// behavioural model of the 16k x 1 dynamic ram behind the controller
`timescale 1ns/100ps
module adc_dram_model
  import adc_pkg::*;
#(
  parameter int GRADE = 0
) (
  input  wire logic             ras_n_i,
  input  wire logic             cas_n_i,
  input  wire logic             we_n_i,
  input  wire logic [ROW_W-1:0] addr_i,
  input  wire logic             din_i,
  output logic                  dout_o
);
  logic              mem [0:(1<<ADDR_W)-1];
  logic [ROW_W-1:0]  row_q;
  logic [ADDR_W-1:0] sel;
  logic              rd;
  logic              early;
  time               ras_t;
  time               cas_t;
  int                acc;

  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 1'b0;
    dout_o = 1'b0;
    ras_t = 0;
    cas_t = 0;
  end

  // row latched on the falling row strobe; every such cycle refreshes it
  always @(negedge ras_n_i) begin
    ras_t = $time;
    // address launches with the strobe; look once it has settled
    #1;
    row_q = addr_i;
  end

  // column fall: early write stores at once and leaves the pin released
  always @(negedge cas_n_i) begin
    if (!ras_n_i) begin
      sel = {addr_i, row_q};
      cas_t = $time;
      early = !we_n_i;
      rd = mem[sel];
      if (early) mem[sel] = din_i;
      acc = max2(T_RAC_NS[GRADE] - int'($time - ras_t), T_CAC_NS[GRADE]);
      // no kinder than silicon: data only after the later access time
      if (!early && acc > 0) #(acc);
      if (!early && !cas_n_i) dout_o = rd;
    end
  end

  // late write keeps read data on the pin; a mistimed one scrambles it
  always @(negedge we_n_i) begin
    if (!cas_n_i && !ras_n_i) begin
      if ($time - cas_t < T_CWD_NS[GRADE] ||
          $time - ras_t < T_RWD_NS[GRADE])
        dout_o = ~dout_o;
      // data may launch with the strobe; take it once it has settled
      #1;
      mem[sel] = din_i;
    end
  end

  // released pin shows the inverse of its last bit, never a stale value
  always @(posedge cas_n_i) begin
    dout_o = ~dout_o;
  end
endmodule

// file: verif/adc_host_chk.sv
// pin-level assertions for the dram cycle controller
`timescale 1ns/100ps
module adc_host_chk
  import adc_pkg::*;
#(
  parameter int GRADE      = 0,
  parameter int INTERVAL_C = 625
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_ready_o,
  input wire logic init_done_o,
  input wire logic dram_ras_n_o,
  input wire logic dram_cas_n_o,
  input wire logic dram_we_n_o,
  input wire logic dram_din_o
);
  localparam int RC_C  = cyc_min(T_RC_NS[GRADE]);
  localparam int RAS_C = cyc_min(T_RAS_NS[GRADE]);
  localparam int MAX_C = cyc_max(STROBE_MAX_NS);
  localparam int CAS_C = cyc_min(T_CAS_NS[GRADE]);
  localparam int CP_C  = cyc_min(T_CP_NS[GRADE]);
  localparam int RP_C  = cyc_min(T_RP_NS[GRADE]);
  localparam int CWD_C = cyc_min(T_CWD_NS[GRADE]);
  localparam int RWD_C = cyc_min(T_RWD_NS[GRADE]);
  localparam int WE_C  = cyc_min(max2(T_WP_NS[GRADE], T_CWL_NS[GRADE]));
  localparam int WCR_C = cyc_min(95);
  logic [15:0] since_q, ras_lo_q, ras_hi_q, cas_lo_q, cas_hi_q, we_lo_q;
  logic [3:0]  falls_q;
  logic        ras_d1_q;

  function automatic logic [15:0] inc(input logic [15:0] x);
    return x + 16'(x != 16'hffff);
  endfunction

  // strobe phase counters, saturating so long idle spans never wrap
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      since_q  <= 16'hffff;
      ras_lo_q <= 16'h0000;
      ras_hi_q <= 16'(RP_C);
      cas_lo_q <= 16'h0000;
      cas_hi_q <= 16'hffff;
      we_lo_q  <= 16'h0000;
    end else begin
      since_q  <= (ras_d1_q && !dram_ras_n_o) ? 16'h0000 : inc(since_q);
      ras_lo_q <= dram_ras_n_o ? 16'h0000 : inc(ras_lo_q);
      ras_hi_q <= dram_ras_n_o ? inc(ras_hi_q) : 16'h0000;
      cas_lo_q <= dram_cas_n_o ? 16'h0000 : inc(cas_lo_q);
      cas_hi_q <= dram_cas_n_o ? inc(cas_hi_q) : 16'h0000;
      we_lo_q  <= dram_we_n_o ? 16'h0000 : inc(we_lo_q);
    end
  end

  // row strobe falls since reset, for the power-up burst
  always_ff @(posedge clk_i) begin
    ras_d1_q <= reset_i ? 1'b1 : dram_ras_n_o;
    if (reset_i) falls_q <= 4'h0;
    else if (ras_d1_q && !dram_ras_n_o && falls_q != 4'hf)
      falls_q <= falls_q + 4'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  cycle_space_a: assert property (
    $fell(dram_ras_n_o) |-> since_q >= RC_C - 1)
    else $error("row strobe cycles too close");
  ras_prech_a: assert property (
    $fell(dram_ras_n_o) |-> ras_hi_q >= RP_C)
    else $error("row precharge too short");
  ras_width_a: assert property (
    $rose(dram_ras_n_o) |-> ras_lo_q >= RAS_C)
    else $error("row strobe pulse too short");
  ras_long_a: assert property (ras_lo_q <= MAX_C)
    else $error("row strobe low too long");
  cas_width_a: assert property (
    $rose(dram_cas_n_o) |-> cas_lo_q >= CAS_C)
    else $error("column strobe pulse too short");
  cas_prech_a: assert property (
    $fell(dram_cas_n_o) |-> cas_hi_q >= CP_C)
    else $error("column precharge too short");
  cas_in_ras_a: assert property (
    !dram_cas_n_o |-> !dram_ras_n_o)
    else $error("column strobe low outside a row cycle");
  late_write_a: assert property (
    $fell(dram_we_n_o) && !dram_cas_n_o
    |-> cas_lo_q >= CWD_C && ras_lo_q >= RWD_C)
    else $error("late write strobe too early");
  early_write_a: assert property (
    $fell(dram_we_n_o) && dram_cas_n_o
    |-> !dram_ras_n_o ##1 $fell(dram_cas_n_o))
    else $error("early write not followed by column strobe");
  we_pulse_a: assert property (
    $rose(dram_we_n_o) |-> we_lo_q >= WE_C)
    else $error("write pulse too short");
  we_hold_a: assert property (
    $rose(dram_we_n_o) |-> since_q >= WCR_C - 1)
    else $error("write released too soon after row fall");
  din_hold_a: assert property (
    !dram_we_n_o && !$past(dram_we_n_o) |-> $stable(dram_din_o))
    else $error("write data moved under write strobe");
  ready_init_a: assert property (req_ready_o |-> init_done_o)
    else $error("ready before initial refreshes");
  init_count_a: assert property (
    $rose(init_done_o) |-> falls_q == INIT_CYCLES)
    else $error("init done after wrong refresh count");
  ras_idle_a: assert property (
    ras_hi_q <= INTERVAL_C + 2 * RC_C)
    else $error("row strobe idle too long");
endmodule

// file: verif/testbench.sv
// self-checking bench for the dram cycle controller and its ram model
`timescale 1ns/100ps
module testbench
  import adc_pkg::*;
;
  localparam int IVL_C = 40;
  logic              clk_i, reset_i, req_valid_i, req_wdata_i;
  adc_cmd_e          req_cmd_i;
  logic [ADDR_W-1:0] req_addr_i;
  logic              req_ready_o, rsp_valid_o, rsp_rdata_o, init_done_o;
  logic              ras_n, cas_n, we_n, din, dout, ras_d1;
  logic [ROW_W-1:0]  maddr;
  logic              shadow [0:(1<<ADDR_W)-1];
  logic [31:0]       lfsr;
  int                fail_count, comparisons, falls, f0;

  adc_host_ctrl #(.GRADE(0), .PAGE_EN(1'b1), .INTERVAL_C(IVL_C)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_cmd_i(req_cmd_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .init_done_o(init_done_o), .dram_ras_n_o(ras_n), .dram_cas_n_o(cas_n),
    .dram_we_n_o(we_n), .dram_addr_o(maddr), .dram_din_o(din),
    .dram_dout_i(dout));

  adc_dram_model #(.GRADE(0)) ram (
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .addr_i(maddr),
    .din_i(din), .dout_o(dout));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // row strobe falls since reset, counted independently of the checker
  always @(posedge clk_i) begin
    ras_d1 <= ras_n;
    if (reset_i) falls <= 0;
    else if (ras_d1 && !ras_n) falls <= falls + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // bounded wait for a level; a spent bound counts against the run
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > lim) begin
        fail_count++;
        $display("CHECK FAILED at %0t: wait bound %h", $time, lim);
        wrap_up();
      end
    end
  endtask

  // one request held until taken; read data compared with the shadow
  task automatic do_req(input adc_cmd_e c, input logic [ADDR_W-1:0] a,
                        input logic d);
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_cmd_i = c;
    req_addr_i = a;
    req_wdata_i = d;
    wait_hi(req_ready_o, 2000);
    @(posedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    if (c != ADC_CMD_WRITE) begin
      wait_hi(rsp_valid_o, 100);
      check(16'(rsp_rdata_o), 16'(shadow[a]));
    end
    shadow[a] = (c == ADC_CMD_READ) ? shadow[a] : d;
  endtask

  // start after reset and check the power-up refresh burst
  task automatic boot;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    wait_hi(init_done_o, 2000);
    check(16'(falls), 16'(INIT_CYCLES));
  endtask

  initial begin
    reset_i = 1'b1;
    req_valid_i = 1'b0;
    req_cmd_i = ADC_CMD_READ;
    req_addr_i = '0;
    req_wdata_i = 1'b0;
    fail_count = 0;
    comparisons = 0;
    lfsr = 32'h9f53;
    for (int i = 0; i < (1 << ADDR_W); i++) shadow[i] = 1'b0;
    boot();
    $display("test init done");
    // boundary addresses, each command, back to back on the first and last rows
    do_req(ADC_CMD_WRITE, 14'h3fff, 1'b1);
    do_req(ADC_CMD_WRITE, 14'h0000, 1'b1);
    do_req(ADC_CMD_RMW, 14'h3fff, 1'b0);
    do_req(ADC_CMD_READ, 14'h3fff, 1'b0);
    do_req(ADC_CMD_READ, 14'h0000, 1'b0);
    $display("test corners done");
    // random traffic on few rows so page hits occur often
    repeat (60) begin
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
      do_req(adc_cmd_e'((lfsr[3:2] == 2'h3) ? 2'h0 : lfsr[3:2]),
             {lfsr[14:8], 4'h0, lfsr[6:4]}, lfsr[20]);
    end
    $display("test random done");
    // idle: refresh keeps running and data survives
    f0 = falls;
    repeat (10 * IVL_C) @(posedge clk_i);
    check(16'(falls - f0 >= 9), 16'h0001);
    do_req(ADC_CMD_READ, 14'h0000, 1'b0);
    $display("test idle done");
    // reset in mid-read, then a fresh burst
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_cmd_i = ADC_CMD_READ;
    repeat (5) @(negedge clk_i);
    reset_i = 1'b1;
    req_valid_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check(16'({ras_n, cas_n, we_n, req_ready_o, rsp_valid_o, init_done_o}),
          16'h0038);
    boot();
    do_req(ADC_CMD_READ, 14'h3fff, 1'b0);
    $display("test reset done");
    wrap_up();
  end
endmodule

bind adc_host_ctrl adc_host_chk #(
  .GRADE(GRADE), .INTERVAL_C(INTERVAL_C)) chk (
  .clk_i(clk_i), .reset_i(reset_i), .req_ready_o(req_ready_o),
  .init_done_o(init_done_o), .dram_ras_n_o(dram_ras_n_o),
  .dram_cas_n_o(dram_cas_n_o), .dram_we_n_o(dram_we_n_o),
  .dram_din_o(dram_din_o));
